/* common/tcc_pkg.sv */
package tcc_pkg;
    // channel count and register layout
    localparam int NCH = 3;
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CTRL2 = 8'h08;
    localparam logic [7:0] OFS_AUX = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [7:0] CH12_WR_MASK = 8'h7f;
    // fields of the auxiliary configuration register
    localparam int AUX_SYNC_POS = 0;
    localparam int AUX_PHASE_POS = 3;
    localparam int AUX_BUFA_POS = 5;
    localparam int AUX_BUFB_POS = 6;
    // fields of the status register
    localparam int STAT_TICK_POS = 0;
    localparam int STAT_CLR_POS = 3;
    localparam int STAT_PIN_POS = 6;
    // ahb transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;
    // prescaler: free counter, one stage per ratio 4, 16, 64, 256, 1024
    localparam int PRE_W = 10;
    localparam int NDIV = 5;
    localparam logic [PRE_W-1:0] PRE_RST = 10'h000;
    localparam logic [PRE_W-1:0] PRE_MASK [NDIV] =
        '{10'h003, 10'h00f, 10'h03f, 10'h0ff, 10'h3ff};
    localparam logic [PRE_W-1:0] PRE_HALF [NDIV] =
        '{10'h002, 10'h008, 10'h020, 10'h080, 10'h200};
    localparam logic [PRE_W-1:0] PRE_ZERO = 10'h000;

    // one channel control register
    typedef struct packed {
        logic [2:0] clr;
        logic [1:0] edg;
        logic [2:0] sel;
    } tcc_ctrl_t;

    // compare match / capture events, bit 0 is register a
    typedef struct packed {
        logic [3:0] ch0;
        logic [1:0] ch1;
        logic [1:0] ch2;
    } tcc_match_t;

    typedef enum logic [3:0] {
        SRC_DIV1, SRC_DIV4, SRC_DIV16, SRC_DIV64, SRC_DIV256, SRC_DIV1024,
        SRC_PIN_A, SRC_PIN_B, SRC_PIN_C, SRC_PIN_D, SRC_NONE
    } tcc_src_t;

    typedef enum logic [2:0] {
        CLR_NONE, CLR_A, CLR_B, CLR_C, CLR_D, CLR_SYNC
    } tcc_clr_t;
endpackage : tcc_pkg

/* hw/tcc_top.sv */
// How it works
// - Channel 0 clear: 000/100 none, 001/010/101/110 regs a-d, 011/111 sync.
// - Channels 1 and 2 clear: 00 none, 01 reg a, 10 reg b, 11 sync.
// - Channels 1 and 2 control bit 7 reads zero and ignores writes.
// - Synchronous clearing acts only while the channel's lockstep bit is one.
// - A buffering register c or d never clears and raises no match event.
// - Both-edge counting gives two counts per prescaled period.
// - In phase counting mode channels 1 and 2 ignore the edge field.
// - Edge choice needs divide 4 or slower; divide 1 counts rising only.
// - Channel 0: codes 000-011 divide 1/4/16/64, 100-111 pins a-d.
// - Ch 1: 000-011 div 1/4/16/64, 100/101 pins a/b, 110 div 256; no 111.
// - Ch 2: 000-011 div 1/4/16/64, 100-110 pins a-c, 111 div 1024.
// - In phase counting mode channels 1 and 2 ignore clock select.
// - Three 8-bit control registers, zeroed by reset and by standby.
// - Each channel picks its clock source on its own.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module tcc_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic standby,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [3:0] ext_count_clock,
    input wire tcc_pkg::tcc_match_t match_evt,
    output logic [2:0] count_tick,
    output logic [2:0] count_clear,
    output logic [1:0] ch0_match_cd
);
    import tcc_pkg::*;

    // clock source decode per channel and code
    function automatic tcc_src_t decode_src(input int ch, input logic [2:0] s);
        tcc_src_t r;
        r = SRC_NONE;
        case (s)
            3'h0: r = SRC_DIV1;
            3'h1: r = SRC_DIV4;
            3'h2: r = SRC_DIV16;
            3'h3: r = SRC_DIV64;
            3'h4: r = SRC_PIN_A;
            3'h5: r = SRC_PIN_B;
            3'h6: r = SRC_NONE; // per-channel meaning set below
            default: r = SRC_NONE;
        endcase
        if (s == 3'h6) begin
            r = (ch == 0) ? SRC_PIN_C : (ch == 1) ? SRC_DIV256 : SRC_PIN_C;
        end
        if (s == 3'h7) begin
            // channel 1 code 111 is prohibited and yields no clock
            r = (ch == 0) ? SRC_PIN_D : (ch == 2) ? SRC_DIV1024 : SRC_NONE;
        end
        return r;
    endfunction : decode_src

    // clear source decode per channel and code
    function automatic tcc_clr_t decode_clr(input int ch, input logic [2:0] c);
        tcc_clr_t r;
        logic [1:0] lo;
        lo = c[1:0];
        r = CLR_NONE;
        case (lo)
            2'h1: r = (ch == 0 && c[2]) ? CLR_C : CLR_A;
            2'h2: r = (ch == 0 && c[2]) ? CLR_D : CLR_B;
            2'h3: r = CLR_SYNC;
            default: r = CLR_NONE;
        endcase
        return r;
    endfunction : decode_clr

    // apply the edge field to a rising/falling pair
    function automatic logic pick_edge(input logic [1:0] e, input logic ri,
                                       input logic fa);
        logic r;
        r = ri;
        if (e == 2'h1) begin
            r = fa;
        end else if (e[1]) begin
            r = ri | fa;
        end
        return r;
    endfunction : pick_edge

    tcc_ctrl_t ctrl_ff [NCH];
    tcc_ctrl_t nxt_ctrl [NCH];
    logic [7:0] aux_ff, nxt_aux;
    logic dp_wr_ff, nxt_dp_wr;
    logic [7:0] dp_addr_ff, nxt_dp_addr;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic hreadyout_ff, hresp_ff;
    logic [3:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
    logic [PRE_W-1:0] pre_ff, nxt_pre;
    logic [2:0] tick_ff, nxt_tick;
    logic [2:0] clear_ff, nxt_clear;
    logic [1:0] cd_ff, nxt_cd;
    logic [NDIV-1:0] pre_rise, pre_fall;
    logic [3:0] pin_rise, pin_fall;
    logic [2:0] own_clr;
    logic grp_clr;
    logic [7:0] stat_val;

    // bus register file: write in the data phase, read in the address one
    always_comb begin
        logic [7:0] wb;
        wb = hwdata[7:0];
        nxt_ctrl = ctrl_ff;
        nxt_aux = aux_ff;
        nxt_dp_wr = hsel & htrans[HTRANS_ACTIVE_BIT] & hready & hwrite;
        nxt_dp_addr = haddr[7:0];
        nxt_hrdata = hrdata_ff;
        if (dp_wr_ff) begin
            case (dp_addr_ff)
                OFS_CTRL0: nxt_ctrl[0] = tcc_ctrl_t'(wb);
                OFS_CTRL1: nxt_ctrl[1] = tcc_ctrl_t'(wb & CH12_WR_MASK);
                OFS_CTRL2: nxt_ctrl[2] = tcc_ctrl_t'(wb & CH12_WR_MASK);
                OFS_AUX: nxt_aux = wb;
                default: nxt_aux = aux_ff;
            endcase
        end
        if (standby) begin
            for (int i = 0; i < NCH; i++) begin
                nxt_ctrl[i] = tcc_ctrl_t'(CTRL_RST);
            end
            nxt_aux = AUX_RST;
        end
        if (hsel & htrans[HTRANS_ACTIVE_BIT] & hready & ~hwrite) begin
            case (haddr[7:0])
                OFS_CTRL0: nxt_hrdata = {24'h000000, nxt_ctrl[0]};
                OFS_CTRL1: nxt_hrdata = {24'h000000, nxt_ctrl[1]};
                OFS_CTRL2: nxt_hrdata = {24'h000000, nxt_ctrl[2]};
                OFS_AUX: nxt_hrdata = {24'h000000, nxt_aux};
                OFS_STAT: nxt_hrdata = {24'h000000, stat_val};
                default: nxt_hrdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl_ff[i] <= tcc_ctrl_t'(CTRL_RST);
            end
            aux_ff <= AUX_RST;
            dp_wr_ff <= 1'b0;
            dp_addr_ff <= 8'h00;
            hrdata_ff <= 32'h00000000;
            hreadyout_ff <= 1'b0;
            hresp_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            aux_ff <= nxt_aux;
            dp_wr_ff <= nxt_dp_wr;
            dp_addr_ff <= nxt_dp_addr;
            hrdata_ff <= nxt_hrdata;
            hreadyout_ff <= 1'b1; // zero wait states
            hresp_ff <= 1'b0;
        end
    end

    // prescaler counter and its per-ratio edge pulses
    always_comb begin
        nxt_pre = pre_ff + 10'h001;
        for (int j = 0; j < NDIV; j++) begin
            pre_rise[j] = (pre_ff & PRE_MASK[j]) == PRE_HALF[j];
            pre_fall[j] = (pre_ff & PRE_MASK[j]) == PRE_ZERO;
        end
    end

    // pin synchroniser: s1 feeds s2 only, edges from s2 against s3
    always_comb begin
        pin_rise = pin_s2_ff & ~pin_s3_ff;
        pin_fall = ~pin_s2_ff & pin_s3_ff;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pre_ff <= PRE_RST;
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
            pin_s3_ff <= 4'h0;
        end else begin
            pre_ff <= nxt_pre;
            pin_s1_ff <= ext_count_clock;
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // count enables, clear requests and gated c/d match events
    always_comb begin
        tcc_src_t src;
        tcc_clr_t cs;
        logic ri;
        logic fa;
        logic phase;
        logic [3:0] m;
        src = SRC_NONE;
        cs = CLR_NONE;
        ri = 1'b0;
        fa = 1'b0;
        phase = 1'b0;
        m = 4'h0;
        nxt_tick = 3'h0;
        own_clr = 3'h0;
        // buffer use of c/d masks their events
        nxt_cd = match_evt.ch0[3:2] &
                 ~{aux_ff[AUX_BUFB_POS], aux_ff[AUX_BUFA_POS]};
        for (int i = 0; i < NCH; i++) begin
            src = decode_src(i, ctrl_ff[i].sel);
            phase = (i != 0) && aux_ff[AUX_PHASE_POS + i - 1];
            case (src)
                SRC_DIV4: begin ri = pre_rise[0]; fa = pre_fall[0]; end
                SRC_DIV16: begin ri = pre_rise[1]; fa = pre_fall[1]; end
                SRC_DIV64: begin ri = pre_rise[2]; fa = pre_fall[2]; end
                SRC_DIV256: begin ri = pre_rise[3]; fa = pre_fall[3]; end
                SRC_DIV1024: begin ri = pre_rise[4]; fa = pre_fall[4]; end
                SRC_PIN_A: begin ri = pin_rise[0]; fa = pin_fall[0]; end
                SRC_PIN_B: begin ri = pin_rise[1]; fa = pin_fall[1]; end
                SRC_PIN_C: begin ri = pin_rise[2]; fa = pin_fall[2]; end
                SRC_PIN_D: begin ri = pin_rise[3]; fa = pin_fall[3]; end
                default: begin ri = 1'b0; fa = 1'b0; end
            endcase
            if (src == SRC_DIV1) begin
                nxt_tick[i] = 1'b1;
            end else begin
                nxt_tick[i] = pick_edge(ctrl_ff[i].edg, ri, fa);
            end
            // phase counting datapath drives the counter instead
            if (phase) begin
                nxt_tick[i] = 1'b0;
            end
            m = (i == 0) ? {nxt_cd, match_evt.ch0[1:0]} :
                (i == 1) ? {2'h0, match_evt.ch1} : {2'h0, match_evt.ch2};
            cs = decode_clr(i, ctrl_ff[i].clr);
            case (cs)
                CLR_A: own_clr[i] = m[0];
                CLR_B: own_clr[i] = m[1];
                CLR_C: own_clr[i] = m[2];
                CLR_D: own_clr[i] = m[3];
                default: own_clr[i] = 1'b0;
            endcase
        end
        grp_clr = |(own_clr & aux_ff[AUX_SYNC_POS +: NCH]);
        for (int i = 0; i < NCH; i++) begin
            cs = decode_clr(i, ctrl_ff[i].clr);
            nxt_clear[i] = own_clr[i] | ((cs == CLR_SYNC) &
                           aux_ff[AUX_SYNC_POS + i] & grp_clr);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_ff <= 3'h0;
            clear_ff <= 3'h0;
            cd_ff <= 2'h0;
        end else begin
            tick_ff <= nxt_tick;
            clear_ff <= nxt_clear;
            cd_ff <= nxt_cd;
        end
    end

    // status readback: last enables, clears and synchronised pins a/b
    assign stat_val = {pin_s2_ff[1:0], clear_ff, tick_ff};

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;
    assign count_tick = tick_ff;
    assign count_clear = clear_ff;
    assign ch0_match_cd = cd_ff;
endmodule : tcc_top
`default_nettype wire

/* sim/tcc_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module tcc_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic standby,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [3:0] ext_count_clock,
    input wire tcc_pkg::tcc_match_t match_evt,
    input wire logic [2:0] count_tick,
    input wire logic [2:0] count_clear,
    input wire logic [1:0] ch0_match_cd
);
    import tcc_pkg::*;
    logic [7:0] sh_ff [4];
    logic wp_ff;
    logic [7:0] wa_ff;
    // shadow copy of control and aux registers from bus writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sh_ff <= '{default: 8'h00};
            wp_ff <= 1'b0;
            wa_ff <= 8'h00;
        end else if (standby) begin
            sh_ff <= '{default: 8'h00};
        end else if (hready) begin
            wp_ff <= hsel && htrans[1] && hwrite;
            wa_ff <= haddr[7:0];
            if (wp_ff && wa_ff <= OFS_AUX)
                sh_ff[wa_ff[3:2]] <= hwdata[7:0];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // bus readiness, clear causes, tick gating
    ready_run_a: assert property (!$past(reset) |-> hreadyout)
        else $error("slave not ready after reset");
    clear_cause_a: assert property (|count_clear |-> |$past(match_evt))
        else $error("clear without a match event");
    a_clear_a: assert property ($past(sh_ff[0][7:5] == 3'h1 &&
        match_evt.ch0[0]) |-> count_clear[0]) else $error("ch0 a clear lost");
    sync_off_a: assert property ($past(sh_ff[1][6:5] == 2'h3 &&
        !sh_ff[3][1]) |-> !count_clear[1]) else $error("unlocked sync clear");
    buf_gate_a: assert property ($past(sh_ff[3][5]) |-> !ch0_match_cd[0])
        else $error("buffered c raised a match");
    div1_tick_a: assert property ($past(!reset &&
        sh_ff[0][2:0] == 3'h0) |-> count_tick[0])
        else $error("undivided clock missed a tick");
    bad_code_a: assert property ($past(sh_ff[1][2:0] == 3'h7) |->
        !count_tick[1]) else $error("ch1 ticked on code 111");
    phase_off_a: assert property ($past(sh_ff[3][4]) |-> !count_tick[2])
        else $error("ch2 ticked in phase mode");
    // main scenarios reached
    sync_clr_c: cover property (count_clear[1] && count_clear[0]);
    cd_evt_c: cover property (ch0_match_cd[0]);
    wr_c: cover property (hsel && htrans[1] && hwrite && hready);
endmodule : tcc_checker
bind tcc_top tcc_checker tcc_checker_i (.clk(clk), .reset(reset),
    .standby(standby), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_count_clock(ext_count_clock), .match_evt(match_evt),
    .count_tick(count_tick), .count_clear(count_clear),
    .ch0_match_cd(ch0_match_cd));
`default_nettype wire

/* sim/tcc_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tcc_top_tb;
    import tcc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic standby = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hreadyout, hresp;
    logic [31:0] hrdata, rd;
    logic [3:0] ext_count_clock = 4'h0;
    tcc_match_t match_evt = '0;
    logic [2:0] count_tick, count_clear;
    logic [1:0] ch0_match_cd;
    int err_count = 0;
    int cmp_count = 0;
    // single slave drives the bus ready
    assign hready = hreadyout;
    tcc_top tcc_top_i (.clk(clk), .reset(reset), .standby(standby),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .ext_count_clock(ext_count_clock), .match_evt(match_evt),
        .count_tick(count_tick), .count_clear(count_clear),
        .ch0_match_cd(ch0_match_cd));
    task complete_run;
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // bounded wait for the slave ready at a rising edge
    task wait_rdy;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            if (hreadyout === 1'b1) return;
        end
        err_count++;
        $display("Error at %0t: bus timeout", $time);
        complete_run();
    endtask : wait_rdy
    task bus(input logic wr, input logic [7:0] a, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy();
        rd = hrdata;
    endtask : bus
    // reconfigure only between scenarios, with pins and matches idle
    task cfg(input logic [7:0] c0, c1, c2, aux);
        bus(1'b1, OFS_CTRL0, c0);
        bus(1'b1, OFS_CTRL1, c1);
        bus(1'b1, OFS_CTRL2, c2);
        bus(1'b1, OFS_AUX, aux);
        repeat (4) @(posedge clk);
    endtask : cfg
    // count ticks per channel while pulsing the pins in mask m
    task ticks(input logic [3:0] m, input int n, e0, e1, e2);
        int c [3];
        c = '{0, 0, 0};
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            for (int k = 0; k < 3; k++) c[k] += count_tick[k];
            ext_count_clock <= (i % 8 < 4 && i < 32) ? m : 4'h0;
        end
        check(c[0], e0);
        check(c[1], e1);
        check(c[2], e2);
    endtask : ticks
    // one match pulse, then collect clears and c/d events
    task pulse(input logic [7:0] m, input logic [2:0] ec,
               input logic [1:0] ed);
        logic [2:0] sc;
        logic [1:0] sd;
        sc = 3'h0;
        sd = 2'h0;
        match_evt <= tcc_match_t'(m);
        @(posedge clk);
        match_evt <= '0;
        repeat (3) begin
            @(posedge clk);
            sc = sc | count_clear;
            sd = sd | ch0_match_cd;
        end
        check(32'(sc), 32'(ec));
        check(32'(sd), 32'(ed));
    endtask : pulse
    task regs_test;
        for (int r = 0; r < 4; r++) begin
            bus(1'b0, 8'(4 * r), 8'h00);
            check(rd, 32'h0);
        end
        check(32'(hresp), 32'h0);
        for (int r = 0; r < 3; r++) begin
            bus(1'b1, 8'(4 * r), 8'hff);
            bus(1'b0, 8'(4 * r), 8'h00);
            check(rd, r == 0 ? 32'hff : 32'h7f);
        end
        bus(1'b1, 8'h14, 8'h5a);
        bus(1'b0, 8'h14, 8'h00);
        check(rd, 32'h0);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        bus(1'b0, OFS_CTRL1, 8'h00);
        check(rd, 32'h0);
    endtask : regs_test
    task tick_test;
        cfg(8'h10, 8'h00, 8'h00, 8'h00);
        ticks(4'h0, 16, 16, 16, 16);
        cfg(8'h01, 8'h11, 8'h07, 8'h00);
        ticks(4'h0, 2048, 512, 1024, 2);
        cfg(8'h0a, 8'h06, 8'h03, 8'h00);
        ticks(4'h0, 1024, 64, 4, 16);
        cfg(8'h03, 8'h19, 8'h1f, 8'h18);
        ticks(4'h0, 256, 4, 0, 0);
        for (int p = 0; p < 4; p++) begin
            cfg(8'(4 + p + 8 * (p % 3)), 8'h07, 8'h04, 8'h00);
            ticks(4'(1 << p), 48, p == 2 ? 8 : 4, 0, p == 0 ? 4 : 0);
        end
    endtask : tick_test
    task clear_test;
        cfg(8'h20, 8'h60, 8'h00, 8'h03);
        pulse(8'h10, 3'h3, 2'h0);
        cfg(8'h20, 8'h60, 8'h00, 8'h01);
        pulse(8'h10, 3'h1, 2'h0);
        cfg(8'h80, 8'h20, 8'h40, 8'h00);
        pulse(8'h13, 3'h4, 2'h0);
        cfg(8'ha0, 8'h00, 8'h00, 8'h00);
        pulse(8'h40, 3'h1, 2'h1);
        cfg(8'ha0, 8'h00, 8'h00, 8'h20);
        pulse(8'h40, 3'h0, 2'h0);
        cfg(8'hc0, 8'h00, 8'h00, 8'h40);
        pulse(8'h80, 3'h0, 2'h0);
        cfg(8'hc0, 8'h00, 8'h00, 8'h00);
        pulse(8'h80, 3'h1, 2'h2);
    endtask : clear_test
    initial begin
        forever #50 clk = ~clk;
    end
    // reset, then the scenarios in turn
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        regs_test();
        tick_test();
        clear_test();
        complete_run();
    end
endmodule : tcc_top_tb
`default_nettype wire
